// file: logic/xbr_pkg.sv
// constants for the port crossbar routing block
package xbr_pkg;
    localparam int NUM_PINS = 24;
    localparam int NUM_FUNCS = 26;
    localparam int ADDR_W = 12;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_ROUTE_A = 8'hE1;
    localparam logic [7:0] IDX_ROUTE_B = 8'hE2;
    localparam logic [7:0] IDX_CTRL = 8'hE3;
    localparam logic [7:0] IDX_BYPASS = 8'hE4;
    localparam logic [7:0] IDX_USED = 8'hE5;
    localparam logic [7:0] ROUTE_A_RST = 8'h00;
    localparam logic [6:0] ROUTE_B_RST = 7'h00;
    localparam logic CTRL_RST = 1'b0;
    localparam logic [23:0] BYPASS_RST = 24'h000000;
    // route A fields
    localparam int A_CMP1_ASYNC = 7;
    localparam int A_CMP1_SYNC = 6;
    localparam int A_CMP0_ASYNC = 5;
    localparam int A_CMP0_SYNC = 4;
    localparam int A_SYSCLK = 3;
    localparam int A_TWO_WIRE = 2;
    localparam int A_PORT_A = 1;
    localparam int A_ASYNC_SERIAL = 0;
    // route B fields
    localparam int B_PORT_B = 6;
    localparam int B_TIMER1 = 5;
    localparam int B_TIMER0 = 4;
    localparam int B_COUNT_IN = 3;
    localparam int B_MOD_LSB = 0;
    localparam int B_MOD_W = 3;
    localparam logic [2:0] MOD_RESERVED = 3'h7;
    localparam int CTRL_ENABLE = 0;
    // functions in decoder priority order
    localparam int FN_TX = 0;
    localparam int FN_RX = 1;
    localparam int FN_PB_SCK = 2;
    localparam int FN_PB_MISO = 3;
    localparam int FN_PB_MOSI = 4;
    localparam int FN_PB_SEL = 5;
    localparam int FN_PA_SCK = 6;
    localparam int FN_PA_SEL = 9;
    localparam int FN_SDA = 10;
    localparam int FN_SCL = 11;
    localparam int FN_CMP0 = 12;
    localparam int FN_CMP0A = 13;
    localparam int FN_CMP1 = 14;
    localparam int FN_CMP1A = 15;
    localparam int FN_SYSCLK = 16;
    localparam int FN_MOD0 = 17;
    localparam int NUM_MODS = 6;
    localparam int FN_COUNT_IN = 23;
    localparam int FN_T0 = 24;
    localparam int FN_T1 = 25;
    localparam int FN_FLEX_FIRST = 6;
    // fixed pin numbers, port n pin m at n*8+m
    localparam int PIN_TX = 4;
    localparam int PIN_RX = 5;
    localparam int PIN_PB_SCK = 16;
endpackage

// file: logic/xbr_slot_assign.sv
// one priority stage: grant the lowest pin not yet taken
`timescale 1ns/10ps
module xbr_slot_assign #(
    parameter int N = 24
) (
    input wire logic req,
    input wire logic [N-1:0] takenIn,
    output logic [N-1:0] grant,
    output logic [N-1:0] takenOut
);
    logic [N-1:0] freeMask;

    always_comb begin
        freeMask = ~takenIn;
        // isolate lowest set bit of the free mask
        grant = req ? (freeMask & N'(~freeMask + N'(1))) : '0;
        takenOut = takenIn | grant;
    end
endmodule // xbr_slot_assign

// file: logic/xbr_crossbar.sv
// port crossbar: routing registers on APB and pin assignment
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
module xbr_crossbar #(
    parameter int NP = xbr_pkg::NUM_PINS,
    parameter int NF = xbr_pkg::NUM_FUNCS
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [xbr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serialPortAFourWire,
    input wire logic serialPortBFourWire,
    input wire logic [NF-1:0] funcOut,
    input wire logic [NF-1:0] funcOe,
    output logic [NF-1:0] funcIn,
    input wire logic [NP-1:0] pinIn,
    input wire logic [NP-1:0] pinPushPull,
    output logic [NP-1:0] pinOut,
    output logic [NP-1:0] pinOeN
);
    logic [7:0] routeA_reg;
    logic [6:0] routeB_reg;
    logic enable_reg;
    logic [NP-1:0] bypass_reg;
    logic [NP-1:0] used_reg;
    logic [NP-1:0] openDrain_reg;
    logic [NF-1:0] req;
    logic [NP-1:0] grant [NF];
    logic [NP-1:0] fixedGrant [xbr_pkg::FN_FLEX_FIRST];
    logic [NP-1:0] taken [NF+1];
    logic [NP-1:0] fixedMask;
    logic [NP-1:0] usedNext;
    logic [NP-1:0] pinOutNext;
    logic [NP-1:0] driveNext;
    logic [NP-1:0] odNext;
    logic [NF-1:0] funcInNext;
    logic [2:0] modCount;
    logic [7:0] regIdx;
    logic setup;
    logic wrDone;
    logic mapped;
    logic [31:0] rdNext;

    // ---------------- APB slave ----------------
    assign regIdx = paddr[9:2];
    assign setup = psel && !penable;
    assign wrDone = psel && penable && pready && pwrite;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0)
        && (regIdx >= xbr_pkg::IDX_ROUTE_A)
        && (regIdx <= xbr_pkg::IDX_USED);

    always_comb begin
        rdNext = 32'h00000000;
        case (regIdx)
            xbr_pkg::IDX_ROUTE_A: rdNext[7:0] = routeA_reg;
            xbr_pkg::IDX_ROUTE_B: rdNext[6:0] = routeB_reg;
            xbr_pkg::IDX_CTRL: rdNext[xbr_pkg::CTRL_ENABLE] = enable_reg;
            xbr_pkg::IDX_BYPASS: rdNext[NP-1:0] = bypass_reg;
            xbr_pkg::IDX_USED: rdNext[NP-1:0] = used_reg;
            default: rdNext = 32'h00000000;
        endcase
    end

    // zero-wait slave: the answer is ready in the first access cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite && mapped) ? rdNext : 32'h00000000;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            routeA_reg <= xbr_pkg::ROUTE_A_RST;
            routeB_reg <= xbr_pkg::ROUTE_B_RST;
            enable_reg <= xbr_pkg::CTRL_RST;
            bypass_reg <= xbr_pkg::BYPASS_RST;
        end else if (wrDone && mapped) begin
            case (regIdx)
                xbr_pkg::IDX_ROUTE_A: routeA_reg <= pwdata[7:0];
                // top bit has no storage, so writes to it vanish
                xbr_pkg::IDX_ROUTE_B: routeB_reg <= pwdata[6:0];
                xbr_pkg::IDX_CTRL: enable_reg <= pwdata[xbr_pkg::CTRL_ENABLE];
                xbr_pkg::IDX_BYPASS: bypass_reg <= pwdata[NP-1:0];
                default: ;
            endcase
        end
    end

    // ---------------- function requests ----------------
    always_comb begin
        req = '0;
        req[xbr_pkg::FN_TX] = routeA_reg[xbr_pkg::A_ASYNC_SERIAL];
        req[xbr_pkg::FN_RX] = routeA_reg[xbr_pkg::A_ASYNC_SERIAL];
        for (int i = 0; i < 3; i++) begin
            req[xbr_pkg::FN_PB_SCK + i] = routeB_reg[xbr_pkg::B_PORT_B];
            req[xbr_pkg::FN_PA_SCK + i] = routeA_reg[xbr_pkg::A_PORT_A];
        end
        req[xbr_pkg::FN_PB_SEL] = routeB_reg[xbr_pkg::B_PORT_B]
            && serialPortBFourWire;
        req[xbr_pkg::FN_PA_SEL] = routeA_reg[xbr_pkg::A_PORT_A]
            && serialPortAFourWire;
        req[xbr_pkg::FN_SDA] = routeA_reg[xbr_pkg::A_TWO_WIRE];
        req[xbr_pkg::FN_SCL] = routeA_reg[xbr_pkg::A_TWO_WIRE];
        req[xbr_pkg::FN_CMP0] = routeA_reg[xbr_pkg::A_CMP0_SYNC];
        req[xbr_pkg::FN_CMP0A] = routeA_reg[xbr_pkg::A_CMP0_ASYNC];
        req[xbr_pkg::FN_CMP1] = routeA_reg[xbr_pkg::A_CMP1_SYNC];
        req[xbr_pkg::FN_CMP1A] = routeA_reg[xbr_pkg::A_CMP1_ASYNC];
        req[xbr_pkg::FN_SYSCLK] = routeA_reg[xbr_pkg::A_SYSCLK];
        for (int i = 0; i < xbr_pkg::NUM_MODS; i++) begin
            // reserved code routes nothing rather than all six
            req[xbr_pkg::FN_MOD0 + i] = (modCount != xbr_pkg::MOD_RESERVED)
                && (i < int'(modCount));
        end
        req[xbr_pkg::FN_COUNT_IN] = routeB_reg[xbr_pkg::B_COUNT_IN];
        req[xbr_pkg::FN_T0] = routeB_reg[xbr_pkg::B_TIMER0];
        req[xbr_pkg::FN_T1] = routeB_reg[xbr_pkg::B_TIMER1];
    end
    assign modCount = routeB_reg[xbr_pkg::B_MOD_LSB +: xbr_pkg::B_MOD_W];

    // ---------------- pin assignment ----------------
    // fixed functions sit on their pins regardless of the bypass mask
    always_comb begin
        for (int f = 0; f < xbr_pkg::FN_FLEX_FIRST; f++) begin
            fixedGrant[f] = '0;
        end
        fixedGrant[xbr_pkg::FN_TX][xbr_pkg::PIN_TX] = req[xbr_pkg::FN_TX];
        fixedGrant[xbr_pkg::FN_RX][xbr_pkg::PIN_RX] = req[xbr_pkg::FN_RX];
        for (int i = 0; i < 4; i++) begin
            fixedGrant[xbr_pkg::FN_PB_SCK + i][xbr_pkg::PIN_PB_SCK + i] =
                req[xbr_pkg::FN_PB_SCK + i];
        end
        fixedMask = bypass_reg;
        for (int f = 0; f < xbr_pkg::FN_FLEX_FIRST; f++) begin
            fixedMask = fixedMask | fixedGrant[f];
        end
    end
    assign taken[xbr_pkg::FN_FLEX_FIRST] = fixedMask;

    // one driver per grant entry: fixed ones here, flexible ones in the chain
    for (genvar f = 0; f < xbr_pkg::FN_FLEX_FIRST; f++) begin : g_fixed
        assign grant[f] = fixedGrant[f];
    end

    // a dropped select line frees its pin for the next function
    for (genvar f = xbr_pkg::FN_FLEX_FIRST; f < NF; f++) begin : g_chain
        xbr_slot_assign #(.N(NP)) u_slot (
            .req(req[f]),
            .takenIn(taken[f]),
            .grant(grant[f]),
            .takenOut(taken[f+1])
        );
    end

    // unrouted function inputs read low
    always_comb begin
        pinOutNext = '0;
        driveNext = '0;
        odNext = ~pinPushPull;
        funcInNext = '0;
        usedNext = '0;
        for (int f = 0; f < NF; f++) begin
            usedNext = usedNext | grant[f];
            for (int p = 0; p < NP; p++) begin
                if (grant[f][p]) begin
                    pinOutNext[p] = funcOut[f];
                    driveNext[p] = funcOe[f];
                    funcInNext[f] = pinIn[p];
                    if (f == xbr_pkg::FN_SDA || f == xbr_pkg::FN_SCL) begin
                        odNext[p] = 1'b1;
                    end
                end
            end
        end
        // open-drain pins only ever pull low
        driveNext = driveNext & ~(odNext & pinOutNext);
        if (!enable_reg) begin
            driveNext = '0;
        end
    end

    // pins are retimed, so routed signals trail their source by a cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pinOut <= '0;
            pinOeN <= '1;
            funcIn <= '0;
            used_reg <= '0;
            openDrain_reg <= '0;
        end else begin
            pinOut <= pinOutNext;
            pinOeN <= ~driveNext;
            funcIn <= enable_reg ? funcInNext : '0;
            used_reg <= usedNext;
            openDrain_reg <= odNext;
        end
    end

    // ---------------- assertions ----------------
    sequence s_setup;
        psel && !penable;
    endsequence

    property p_apb_answer;
        @(posedge core_clk) disable iff (!nrst)
        s_setup |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("no answer in first access cycle");

    property p_write_a;
        @(posedge core_clk) disable iff (!nrst)
        (wrDone && regIdx == xbr_pkg::IDX_ROUTE_A && mapped)
            |=> routeA_reg == $past(pwdata[7:0]);
    endproperty
    a_write_a: assert property (p_write_a)
        else $error("route A write lost");

    property p_top_zero;
        @(posedge core_clk) disable iff (!nrst)
        (s_setup and (!pwrite && regIdx == xbr_pkg::IDX_ROUTE_B && mapped))
            |=> prdata[7] == 1'b0 && prdata[6:0] == routeB_reg;
    endproperty
    a_top_zero: assert property (p_top_zero)
        else $error("route B top bit not zero");

    property p_disabled;
        @(posedge core_clk) disable iff (!nrst)
        !enable_reg |=> pinOeN == '1;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("pin driven with crossbar off");

    property p_tx_pin;
        @(posedge core_clk) disable iff (!nrst)
        (enable_reg && routeA_reg[xbr_pkg::A_ASYNC_SERIAL])
            |=> pinOut[xbr_pkg::PIN_TX] == $past(funcOut[xbr_pkg::FN_TX])
                && funcIn[xbr_pkg::FN_RX] == $past(pinIn[xbr_pkg::PIN_RX]);
    endproperty
    a_tx_pin: assert property (p_tx_pin)
        else $error("serial lines not on fixed pins");

    property p_port_b;
        @(posedge core_clk) disable iff (!nrst)
        (routeB_reg[xbr_pkg::B_PORT_B]
            && routeA_reg[xbr_pkg::A_ASYNC_SERIAL] == 1'b0)
            |=> used_reg[xbr_pkg::PIN_PB_SCK +: 3] == 3'h7
                && (!$past(serialPortBFourWire)
                    || used_reg[xbr_pkg::PIN_PB_SCK + 3]);
    endproperty
    a_port_b: assert property (p_port_b)
        else $error("port B pins wrong");

    property p_port_a_shift;
        @(posedge core_clk) disable iff (!nrst)
        (routeA_reg == 8'h12 && routeB_reg == 7'h00 && bypass_reg == '0)
            |=> used_reg == ($past(serialPortAFourWire) ?
                24'h00001F : 24'h00000F);
    endproperty
    a_port_a_shift: assert property (p_port_a_shift)
        else $error("wire mode did not shift pins");

    property p_lowest_free;
        @(posedge core_clk) disable iff (!nrst)
        (routeA_reg == 8'h10 && routeB_reg == 7'h00 && bypass_reg == 24'h1)
            |=> used_reg == 24'h000002;
    endproperty
    a_lowest_free: assert property (p_lowest_free)
        else $error("not lowest free pin");

    property p_reserved;
        @(posedge core_clk) disable iff (!nrst)
        (routeB_reg == 7'h07 && routeA_reg == 8'h00)
            |=> used_reg == '0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code routed pins");

    property p_mod_count;
        @(posedge core_clk) disable iff (!nrst)
        (routeB_reg == 7'h03 && routeA_reg == 8'h00 && bypass_reg == '0)
            |=> used_reg == 24'h000007;
    endproperty
    a_mod_count: assert property (p_mod_count)
        else $error("array pin count wrong");

    property p_open_drain;
        @(posedge core_clk) disable iff (!nrst)
        !(|(openDrain_reg & ~pinOeN & pinOut));
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin driven high");

    property p_err_ready;
        @(posedge core_clk) disable iff (!nrst)
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error answer without ready");

    // two-wire alone with nothing bypassed lands on the two lowest pins
    property p_two_wire_od;
        @(posedge core_clk) disable iff (!nrst)
        (routeA_reg == 8'h04 && bypass_reg == '0)
            |=> openDrain_reg[1:0] == 2'h3;
    endproperty
    a_two_wire_od: assert property (p_two_wire_od)
        else $error("two-wire pins not open-drain");
endmodule // xbr_crossbar

// file: tb/xbr_pad_model.sv
// pad-side model: wired level seen at each pin
`timescale 1ns/10ps
module xbr_pad_model (
    input wire logic [23:0] pinOut,
    input wire logic [23:0] pinOeN,
    input wire logic [23:0] extVal,
    output logic [23:0] pinIn
);
    // an undriven pad shows the outside level, never a stale driven value
    assign pinIn = (pinOeN & extVal) | (~pinOeN & pinOut);
endmodule // xbr_pad_model

// file: tb/crossbar_peripheral_routing_test.sv
// self-checking bench for the port crossbar routing block
`timescale 1ns/10ps
module crossbar_peripheral_routing_test;
    typedef struct {
        logic [7:0] a;
        logic [7:0] b;
        logic [23:0] byp;
        logic fa;
        logic fb;
        logic [23:0] used;
    } xbr_row_type;
    logic core_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic er, fourA, fourB;
    logic [25:0] funcOut, funcOe, funcIn;
    logic [23:0] pinIn, pinPushPull, pinOut, pinOeN, extVal;
    int errCount, nTests;
    int pinOf [26];
    xbr_row_type rows [14];

    xbr_crossbar DUT (.core_clk(core_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serialPortAFourWire(fourA), .serialPortBFourWire(fourB),
        .funcOut(funcOut), .funcOe(funcOe), .funcIn(funcIn), .pinIn(pinIn),
        .pinPushPull(pinPushPull), .pinOut(pinOut), .pinOeN(pinOeN));
    xbr_pad_model PADS (.pinOut(pinOut), .pinOeN(pinOeN), .extVal(extVal),
        .pinIn(pinIn));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [11:0] addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task reportAndStop;
        if (errCount == 0 && nTests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errCount++;
            $display("FAIL %0t bus answer never came", $time);
            reportAndStop();
        end
    endtask

    task wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, addr(idx), d);
        chk(er, 1'b0, "write error");
    endtask

    task rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, addr(idx), 32'h0);
        chk(rd, exp, "read data");
    endtask

    // reference pin plan: fixed pins first, then lowest free unbypassed pin
    task calc(input logic [7:0] a, input logic [7:0] b,
              input logic [23:0] byp, input logic fa, input logic fb);
        logic [23:0] t;
        logic en;
        t = 24'h000000;
        for (int f = 0; f < 26; f++) pinOf[f] = -1;
        if (a[0]) begin
            pinOf[0] = 4;
            pinOf[1] = 5;
            t[5:4] = 2'h3;
        end
        if (b[6]) begin
            for (int k = 0; k < 3 + fb; k++) begin
                pinOf[2 + k] = 16 + k;
                t[16 + k] = 1'b1;
            end
        end
        for (int f = 6; f < 26; f++) begin
            en = (f < 9) ? a[1] : (f == 9) ? (a[1] & fa) : (f < 12) ? a[2] :
                 (f == 12) ? a[4] : (f == 13) ? a[5] : (f == 14) ? a[6] :
                 (f == 15) ? a[7] : (f == 16) ? a[3] :
                 (f < 23) ? ((f - 17) < b[2:0] && b[2:0] != 3'h7) : b[f - 20];
            for (int p = 0; p < 24 && en; p++) begin
                if (!t[p] && !byp[p]) begin
                    pinOf[f] = p;
                    t[p] = 1'b1;
                    en = 1'b0;
                end
            end
        end
    endtask

    task checkRow(input logic [23:0] used);
        logic [23:0] eOeN, eOut, mask;
        logic [25:0] eIn, pat;
        for (int k = 0; k < 2; k++) begin
            pat = k ? 26'h0E3C5A6 : 26'h31C3A59;
            funcOut <= pat;
            funcOe <= 26'h3FFFFFF;
            repeat (3) @(posedge core_clk);
            eOeN = 24'hFFFFFF;
            eOut = 24'h000000;
            mask = 24'h000000;
            for (int f = 0; f < 26; f++) begin
                if (pinOf[f] >= 0) begin
                    // two-wire lines are open-drain: only a low is driven
                    eOeN[pinOf[f]] = (f == 10 || f == 11) ? pat[f] : 1'b0;
                    eOut[pinOf[f]] = pat[f];
                    mask[pinOf[f]] = !(f == 10 || f == 11);
                end
            end
            chk(pinOeN, eOeN, "pin drive");
            chk(pinOut & mask, eOut & mask, "pin value");
        end
        funcOe <= 26'h0000000;
        repeat (3) @(posedge core_clk);
        eIn = 26'h0000000;
        for (int f = 0; f < 26; f++) if (pinOf[f] >= 0) eIn[f] = extVal[pinOf[f]];
        chk(funcIn, eIn, "func input");
        rdchk(xbr_pkg::IDX_USED, used);
    endtask

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fourA = 1'b0;
        fourB = 1'b0;
        funcOut = 26'h0000000;
        funcOe = 26'h0000000;
        pinPushPull = 24'hFFFFFF;
        extVal = 24'h5A3C96;
        errCount = 0;
        nTests = 0;
        rows[0] = '{8'h01, 8'h00, 24'h000000, 1'b0, 1'b0, 24'h000030};
        rows[1] = '{8'h02, 8'h00, 24'h000000, 1'b0, 1'b0, 24'h000007};
        rows[2] = '{8'h12, 8'h00, 24'h000000, 1'b1, 1'b0, 24'h00001F};
        rows[3] = '{8'h13, 8'h00, 24'h000000, 1'b0, 1'b0, 24'h00003F};
        rows[4] = '{8'h00, 8'h40, 24'h000000, 1'b0, 1'b0, 24'h070000};
        rows[5] = '{8'h04, 8'h40, 24'h000000, 1'b0, 1'b1, 24'h0F0003};
        rows[6] = '{8'hF8, 8'h00, 24'h000000, 1'b0, 1'b0, 24'h00001F};
        rows[7] = '{8'h00, 8'h3E, 24'h000000, 1'b0, 1'b0, 24'h0001FF};
        rows[8] = '{8'h00, 8'h07, 24'h000000, 1'b0, 1'b0, 24'h000000};
        rows[9] = '{8'hFF, 8'h7E, 24'h00000F, 1'b1, 1'b1, 24'hFFFFF0};
        rows[10] = '{8'h00, 8'hFF, 24'h000000, 1'b0, 1'b0, 24'h070007};
        rows[11] = '{8'h00, 8'h03, 24'h000000, 1'b0, 1'b0, 24'h000007};
        rows[12] = '{8'h10, 8'h00, 24'h000001, 1'b0, 1'b0, 24'h000002};
        rows[13] = '{8'h00, 8'h01, 24'h000001, 1'b0, 1'b0, 24'h000002};
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        chk(pinOeN, 24'hFFFFFF, "reset drive");
        for (int i = 0; i < 5; i++) rdchk(8'(xbr_pkg::IDX_ROUTE_A + i), 32'h0);
        wr(xbr_pkg::IDX_ROUTE_A, 32'hFF);
        wr(xbr_pkg::IDX_ROUTE_B, 32'h7E);
        funcOe <= 26'h3FFFFFF;
        repeat (3) @(posedge core_clk);
        chk(pinOeN, 24'hFFFFFF, "drive while off");
        chk(funcIn, 26'h0, "input while off");
        wr(xbr_pkg::IDX_CTRL, 32'h1);
        foreach (rows[r]) begin
            fourA <= rows[r].fa;
            fourB <= rows[r].fb;
            wr(xbr_pkg::IDX_ROUTE_A, {24'h0, rows[r].a});
            wr(xbr_pkg::IDX_ROUTE_B, {24'h0, rows[r].b});
            wr(xbr_pkg::IDX_BYPASS, {8'h0, rows[r].byp});
            calc(rows[r].a, rows[r].b, rows[r].byp, rows[r].fa, rows[r].fb);
            checkRow(rows[r].used);
        end
        // array pin zero sits on pin 1; make that pin open-drain
        pinPushPull <= 24'hFFFFFD;
        funcOe <= 26'h3FFFFFF;
        funcOut <= 26'h0020000;
        repeat (3) @(posedge core_clk);
        chk(pinOeN, 24'hFFFFFF, "open-drain high");
        funcOut <= 26'h0000000;
        repeat (3) @(posedge core_clk);
        chk(pinOeN, 24'hFFFFFD, "open-drain low");
        pinPushPull <= 24'hFFFFFF;
        wr(xbr_pkg::IDX_ROUTE_B, 32'hFF);
        rdchk(xbr_pkg::IDX_ROUTE_B, 32'h7F);
        apb(1'b1, addr(xbr_pkg::IDX_USED), 32'h0);
        rdchk(xbr_pkg::IDX_USED, 32'h07000E);
        apb(1'b0, 12'h100, 32'h0);
        chk(er, 1'b1, "unmapped error");
        apb(1'b1, 12'h385, 32'h0);
        chk(er, 1'b1, "misaligned error");
        rdchk(xbr_pkg::IDX_ROUTE_A, 32'h0);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(pinOeN, 24'hFFFFFF, "mid reset drive");
        nrst <= 1'b1;
        rdchk(xbr_pkg::IDX_ROUTE_B, 32'h0);
        reportAndStop();
    end
endmodule // crossbar_peripheral_routing_test
